// File: design/pmc_regs.sv
// Notes on behaviour
// - Table status reads 0 to 3
// - Above threshold add gain times excess
// - Gain LSB 1/64, range 0 to 255/64
// - Timing register sets monotonic sample instants
// - Bits 5:3 first sample 0.5-2.25 ms
// - Bits 2:0 spacing 0.75-1.75 ms
// - Base code in 7:5, steps sixteen
// - Blank store at supply cycle gives code 1
// - New base address after supply cycle
// - Read-only CRC16 for both tables
// - Config CRC checked, computed value readable
// - Mismatch: recovery, memory fault, 0xB0
// - Sign-magnitude offset on current mantissa
// - Gain trim multiplies current reading
// - Later sample must exceed earlier by more than step; step 0 disables the check
// - Writes need general unlock password first
`timescale 1ns/100ps
`include "pmc_defines.svh"

module pmc_regs #(
  parameter int QUARTER_CYCLES = `PMC_QUARTER_MS_US * `PMC_CLK_MHZ,
  parameter logic [15:0] CRC_POLY = `PMC_CRC_POLY,
  parameter logic [15:0] CRC_INIT = `PMC_CRC_INIT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command port
  input pmc_pkg::pmc_cmd_t cmd,
  output pmc_pkg::pmc_rsp_t rsp,
  // Stored table status
  input wire logic temp_lut_stored,
  input wire logic gain_lut_stored,
  input wire logic [15:0] temp_lut_crc,
  input wire logic [15:0] gain_lut_crc,
  // Configuration file stream
  input wire logic cfg_start,
  input wire logic cfg_byte_valid,
  input wire logic [7:0] cfg_byte,
  input wire logic cfg_last,
  input wire logic [15:0] cfg_signature,
  // Supply cycle and store state
  input wire logic supply_restored,
  input wire logic cfg_blank,
  output logic [7:0] bus_addr,
  output logic recovery,
  output logic mem_fault,
  // Current measurement path
  input pmc_pkg::pmc_meas_t iout_raw,
  output pmc_pkg::pmc_meas_t iout_cal,
  // Soft-start monotonic check
  input wire logic ss_start,
  input wire logic ss_end,
  input wire logic [15:0] vout_mant,
  output logic ss_fault
);

  //--------------------------------------------------
  // Helper functions
  //--------------------------------------------------

  // One byte step of the CRC16
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Gain scaling above one threshold, saturated
  function automatic logic [10:0] over_th(input logic [10:0] x, input logic [15:0] th,
                                         input logic [7:0] g);
    logic [18:0] prod;
    logic [13:0] sum; // Wide enough for full-scale gain times full-scale excess
    prod = 19'h0_0000;
    sum = {3'b000, x};
    if (th[`PMC_MANT_MSB:0] != 11'h000 && x > th[`PMC_MANT_MSB:0]) begin
      prod = g * (x - th[`PMC_MANT_MSB:0]);
      sum = {3'b000, x} + 14'(prod >> `PMC_GAIN_FRAC);
    end
    return (sum[13:11] != 3'b000) ? 11'h7FF : sum[10:0];
  endfunction

  // Quarter milliseconds until the next sample
  function automatic logic [3:0] pace_q(input logic [2:0] code);
    return (code < `PMC_SS_PACE_MIN) ? {1'b0, `PMC_SS_PACE_MIN} : {1'b0, code};
  endfunction

  //--------------------------------------------------
  // State
  //--------------------------------------------------
  pmc_pkg::pmc_state_t st; // Registered state
  pmc_pkg::pmc_state_t next_st; // Next state

  //--------------------------------------------------
  // Next-state logic
  //--------------------------------------------------
  always_comb begin
    logic wr_ok; // Write permitted
    logic [12:0] ofs_v; // Offset result
    logic [18:0] mul_v; // Gain trim product
    logic [10:0] trim_v; // Trimmed mantissa
    logic [16:0] need_v; // Required later sample
    logic [15:0] crc_n; // Updated CRC
    wr_ok = 1'b0;
    ofs_v = 13'h0000;
    mul_v = 19'h0_0000;
    trim_v = 11'h000;
    need_v = 17'h0_0000;
    crc_n = 16'h0000;
    next_st = st;
    next_st.rsp = '0;

    // Command handling
    if (cmd.valid) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.ack = 1'b1;
      wr_ok = cmd.write && st.gen_ok;
      if (cmd.write) begin
        case (cmd.code)
          // Password entry
          `PMC_CMD_GEN_UNLOCK: begin
            next_st.gen_ok = (cmd.data == `PMC_GEN_PASS);
          end
          `PMC_CMD_ADDR_UNLOCK: begin
            next_st.addr_ok = st.gen_ok && (cmd.data == `PMC_ADDR_PASS);
          end
          // Writable settings
          `PMC_CMD_SS_STEP: begin
            if (wr_ok) begin
              next_st.ss_step = cmd.data[7:0];
            end
          end
          `PMC_CMD_TH_ONE: begin
            if (wr_ok) begin
              next_st.th_one = cmd.data;
            end
          end
          `PMC_CMD_GAIN_ONE: begin
            if (wr_ok) begin
              next_st.gain_one = cmd.data[7:0];
            end
          end
          `PMC_CMD_TH_TWO: begin
            if (wr_ok) begin
              next_st.th_two = cmd.data;
            end
          end
          `PMC_CMD_GAIN_TWO: begin
            if (wr_ok) begin
              next_st.gain_two = cmd.data[7:0];
            end
          end
          `PMC_CMD_SS_TIMING: begin
            if (wr_ok) begin
              next_st.ss_timing = cmd.data[5:0];
            end
          end
          `PMC_CMD_BASE_ADDR: begin
            if (wr_ok && st.addr_ok) begin
              next_st.base_code = cmd.data[`PMC_BASE_MSB:`PMC_BASE_LSB];
            end
          end
          `PMC_CMD_OFS_TRIM: begin
            if (wr_ok) begin
              next_st.ofs_trim = cmd.data[7:0];
            end
          end
          `PMC_CMD_MULT_TRIM: begin
            if (wr_ok) begin
              next_st.mult_trim = cmd.data[7:0];
            end
          end
          default: begin
            next_st.rsp.ack = 1'b0;
          end
        endcase
      end else begin
        case (cmd.code)
          // Readback
          `PMC_CMD_SS_STEP: next_st.rsp.data = {8'h00, st.ss_step};
          `PMC_CMD_LUT_STATUS: next_st.rsp.data = {14'h0000, gain_lut_stored, temp_lut_stored};
          `PMC_CMD_TH_ONE: next_st.rsp.data = st.th_one;
          `PMC_CMD_GAIN_ONE: next_st.rsp.data = {8'h00, st.gain_one};
          `PMC_CMD_TH_TWO: next_st.rsp.data = st.th_two;
          `PMC_CMD_GAIN_TWO: next_st.rsp.data = {8'h00, st.gain_two};
          `PMC_CMD_SS_TIMING: next_st.rsp.data = {10'h000, st.ss_timing};
          `PMC_CMD_BASE_ADDR: next_st.rsp.data = {8'h00, st.base_code, 5'h00};
          `PMC_CMD_TEMP_CRC: next_st.rsp.data = temp_lut_crc;
          `PMC_CMD_GAIN_CRC: next_st.rsp.data = gain_lut_crc;
          `PMC_CMD_CFG_CRC: next_st.rsp.data = st.cfg_crc;
          `PMC_CMD_OFS_TRIM: next_st.rsp.data = {8'h00, st.ofs_trim};
          `PMC_CMD_MULT_TRIM: next_st.rsp.data = {8'h00, st.mult_trim};
          default: next_st.rsp.ack = 1'b0;
        endcase
      end
    end

    // Configuration CRC check
    case (st.ck_st)
      pmc_pkg::CK_IDLE: begin
        if (cfg_start) begin
          next_st.crc_acc = CRC_INIT;
          next_st.ck_st = pmc_pkg::CK_RUN;
        end
      end
      pmc_pkg::CK_RUN: begin
        if (cfg_byte_valid) begin
          crc_n = crc_byte(st.crc_acc, cfg_byte);
          next_st.crc_acc = crc_n;
          if (cfg_last) begin
            next_st.cfg_crc = crc_n;
            next_st.ck_st = pmc_pkg::CK_IDLE;
            next_st.recovery = (crc_n != cfg_signature);
            if (crc_n != cfg_signature) begin
              // Recovery runs with reset settings; ss_timing and base_code kept
              next_st.mem_fault = 1'b1;
              next_st.th_one = 16'h0000;
              next_st.th_two = 16'h0000;
              next_st.gain_one = 8'h00;
              next_st.gain_two = 8'h00;
              next_st.ofs_trim = 8'h00;
              next_st.mult_trim = `PMC_TRIM_RESET;
              next_st.ss_step = 8'h00;
            end
          end
        end
      end
      default: next_st.ck_st = pmc_pkg::CK_IDLE;
    endcase

    // Base address takes effect only on a supply cycle
    if (supply_restored) begin
      next_st.live_code = cfg_blank ? `PMC_BASE_DEFAULT : st.base_code;
    end
    next_st.bus_addr = st.recovery ? `PMC_RECOVERY_ADDR : {1'b0, st.live_code, 4'h0};

    // Stage one: offset then gain trim
    next_st.s1.valid = iout_raw.valid;
    if (st.ofs_trim[`PMC_OFS_SIGN]) begin
      ofs_v = {2'b00, iout_raw.mant} - {6'h00, st.ofs_trim[6:0]};
    end else begin
      ofs_v = {2'b00, iout_raw.mant} + {6'h00, st.ofs_trim[6:0]};
    end
    if (ofs_v[12]) begin
      trim_v = 11'h000;
    end else if (ofs_v[11]) begin
      trim_v = 11'h7FF;
    end else begin
      trim_v = ofs_v[10:0];
    end
    mul_v = trim_v * st.mult_trim;
    mul_v = mul_v >> `PMC_TRIM_FRAC;
    next_st.s1.mant = (mul_v[18:11] != 8'h00) ? 11'h7FF : mul_v[10:0];

    // Stages two and three: threshold scaling in order
    next_st.s2.valid = st.s1.valid;
    next_st.s2.mant = over_th(st.s1.mant, st.th_one, st.gain_one);
    next_st.out.valid = st.s2.valid;
    next_st.out.mant = over_th(st.s2.mant, st.th_two, st.gain_two);

    // Quarter-millisecond tick
    if (st.ss_st == pmc_pkg::SS_IDLE || st.tick_cnt == 16'(QUARTER_CYCLES - 1)) begin
      next_st.tick_cnt = 16'h0000;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end

    // Soft-start monotonic check
    need_v = {1'b0, st.prev_v} + {9'h000, st.ss_step};
    case (st.ss_st)
      pmc_pkg::SS_IDLE: begin
        if (ss_start) begin
          next_st.ss_fault = 1'b0;
          next_st.q_cnt = `PMC_SS_INIT_BASE_Q + {1'b0, st.ss_timing[`PMC_SS_INIT_MSB:`PMC_SS_INIT_LSB]};
          next_st.ss_st = pmc_pkg::SS_FIRST;
        end
      end
      pmc_pkg::SS_FIRST: begin
        if (ss_end) begin
          next_st.ss_st = pmc_pkg::SS_IDLE;
        end else if (st.tick_cnt == 16'(QUARTER_CYCLES - 1)) begin
          next_st.q_cnt = st.q_cnt - 4'h1;
          if (st.q_cnt == 4'h1) begin
            next_st.prev_v = vout_mant;
            next_st.q_cnt = pace_q(st.ss_timing[`PMC_SS_PACE_MSB:0]);
            next_st.ss_st = pmc_pkg::SS_NEXT;
          end
        end
      end
      pmc_pkg::SS_NEXT: begin
        if (ss_end) begin
          next_st.ss_st = pmc_pkg::SS_IDLE;
        end else if (st.tick_cnt == 16'(QUARTER_CYCLES - 1)) begin
          next_st.q_cnt = st.q_cnt - 4'h1;
          if (st.q_cnt == 4'h1) begin
            if (st.ss_step != 8'h00 && {1'b0, vout_mant} <= need_v) begin
              next_st.ss_fault = 1'b1;
            end
            next_st.prev_v = vout_mant;
            next_st.q_cnt = pace_q(st.ss_timing[`PMC_SS_PACE_MSB:0]);
          end
        end
      end
      default: next_st.ss_st = pmc_pkg::SS_IDLE;
    endcase
  end

  //--------------------------------------------------
  // State register
  //--------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.base_code <= `PMC_BASE_DEFAULT;
      st.live_code <= `PMC_BASE_DEFAULT;
      st.bus_addr <= {1'b0, `PMC_BASE_DEFAULT, 4'h0};
      st.mult_trim <= `PMC_TRIM_RESET;
      st.crc_acc <= `PMC_CRC_INIT;
      st.ck_st <= pmc_pkg::CK_IDLE;
      st.ss_st <= pmc_pkg::SS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  //--------------------------------------------------
  // Outputs
  //--------------------------------------------------
  assign rsp = st.rsp;
  assign bus_addr = st.bus_addr;
  assign recovery = st.recovery;
  assign mem_fault = st.mem_fault;
  assign iout_cal = st.out;
  assign ss_fault = st.ss_fault;

endmodule

// File: design/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// Command codes
`define PMC_CMD_GEN_UNLOCK 8'hC4
`define PMC_CMD_ADDR_UNLOCK 8'hC6
`define PMC_CMD_SS_STEP 8'hD4
`define PMC_CMD_LUT_STATUS 8'hD8
`define PMC_CMD_TH_ONE 8'hD9
`define PMC_CMD_GAIN_ONE 8'hDA
`define PMC_CMD_TH_TWO 8'hDB
`define PMC_CMD_GAIN_TWO 8'hDC
`define PMC_CMD_SS_TIMING 8'hDF
`define PMC_CMD_BASE_ADDR 8'hE0
`define PMC_CMD_TEMP_CRC 8'hE1
`define PMC_CMD_GAIN_CRC 8'hE2
`define PMC_CMD_CFG_CRC 8'hEE
`define PMC_CMD_OFS_TRIM 8'hF0
`define PMC_CMD_MULT_TRIM 8'hF1
// Passwords and addresses
`define PMC_GEN_PASS 16'hC93F
`define PMC_ADDR_PASS 16'hF1C0
`define PMC_RECOVERY_ADDR 8'hB0
`define PMC_BASE_DEFAULT 3'h1
// Field positions
`define PMC_BASE_MSB 7
`define PMC_BASE_LSB 5
`define PMC_MANT_MSB 10
`define PMC_OFS_SIGN 7
`define PMC_SS_INIT_MSB 5
`define PMC_SS_INIT_LSB 3
`define PMC_SS_PACE_MSB 2
// Fixed-point scaling and reset values
`define PMC_GAIN_FRAC 6
`define PMC_TRIM_FRAC 7
`define PMC_TRIM_RESET 8'h80
`define PMC_CRC_INIT 16'hFFFF
`define PMC_CRC_POLY 16'h1021
// Soft-start timing
`define PMC_QUARTER_MS_US 250
`define PMC_CLK_MHZ 200
`define PMC_SS_INIT_BASE_Q 4'h2
`define PMC_SS_PACE_MIN 3'h3
`endif

// File: design/pmc_pkg.sv
package pmc_pkg;
  // Command from the bus front end
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } pmc_cmd_t;
  // Answer to a command
  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] data;
  } pmc_rsp_t;
  // Current measurement sample
  typedef struct packed {
    logic valid;
    logic [10:0] mant;
  } pmc_meas_t;
  typedef enum logic [1:0] {SS_IDLE, SS_FIRST, SS_NEXT} pmc_ss_st_t;
  typedef enum logic {CK_IDLE, CK_RUN} pmc_ck_st_t;
  // All state of the register bank
  typedef struct packed {
    pmc_rsp_t rsp;
    logic gen_ok;
    logic addr_ok;
    logic [7:0] ss_step;
    logic [15:0] th_one;
    logic [7:0] gain_one;
    logic [15:0] th_two;
    logic [7:0] gain_two;
    logic [5:0] ss_timing;
    logic [2:0] base_code;
    logic [2:0] live_code;
    logic recovery;
    logic mem_fault;
    logic [15:0] cfg_crc;
    logic [15:0] crc_acc;
    pmc_ck_st_t ck_st;
    logic [7:0] ofs_trim;
    logic [7:0] mult_trim;
    pmc_meas_t s1;
    pmc_meas_t s2;
    pmc_meas_t out;
    pmc_ss_st_t ss_st;
    logic [15:0] tick_cnt;
    logic [3:0] q_cnt;
    logic [15:0] prev_v;
    logic ss_fault;
    logic [7:0] bus_addr;
  } pmc_state_t;
endpackage

// File: tb/pmc_regs_checker.sv
`timescale 1ns/100ps
module pmc_regs_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command port
  input pmc_pkg::pmc_cmd_t cmd,
  input pmc_pkg::pmc_rsp_t rsp,
  // Table status inputs
  input wire logic temp_lut_stored,
  input wire logic gain_lut_stored,
  // Address and fault state
  input wire logic supply_restored,
  input wire logic [7:0] bus_addr,
  input wire logic recovery,
  input wire logic mem_fault,
  // Current path
  input pmc_pkg::pmc_meas_t iout_raw,
  input pmc_pkg::pmc_meas_t iout_cal
);
  // ----
  // Port relations
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rsp_next;
    cmd.valid |=> rsp.valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("no answer after command");
  property p_lut_status;
    cmd.valid && !cmd.write && cmd.code == 8'hd8 |=> rsp.data == {14'h0000, $past(gain_lut_stored), $past(temp_lut_stored)};
  endproperty
  a_lut_status: assert property (p_lut_status) else $error("table status wrong");
  property p_iout_delay;
    iout_raw.valid |-> ##3 iout_cal.valid;
  endproperty
  a_iout_delay: assert property (p_iout_delay) else $error("current sample lost");
  property p_recov_addr;
    recovery && $past(recovery) |-> bus_addr == 8'hb0;
  endproperty
  a_recov_addr: assert property (p_recov_addr) else $error("recovery address wrong");
  property p_recov_fault;
    $rose(recovery) |-> mem_fault;
  endproperty
  a_recov_fault: assert property (p_recov_fault) else $error("fault flag missing");
  property p_fault_sticky;
    mem_fault |=> mem_fault;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag dropped");
  property p_addr_form;
    !recovery && !$past(recovery) |-> bus_addr[7] == 1'b0 && bus_addr[3:0] == 4'h0;
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("address not on sixteen");
  property p_addr_hold;
    $changed(bus_addr) |-> $past(supply_restored) || $past(supply_restored, 2) || $past(recovery) != $past(recovery, 2);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved early");
  // Main scenarios reached
  c_write: cover property (cmd.valid && cmd.write);
  c_recovery: cover property ($rose(recovery));
  c_iout: cover property (iout_cal.valid);
endmodule
bind pmc_regs pmc_regs_checker i_chk (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .rsp(rsp),
  .temp_lut_stored(temp_lut_stored), .gain_lut_stored(gain_lut_stored), .supply_restored(supply_restored),
  .bus_addr(bus_addr), .recovery(recovery), .mem_fault(mem_fault), .iout_raw(iout_raw), .iout_cal(iout_cal));

// File: tb/pmc_host.sv
`timescale 1ns/100ps
module pmc_host (
  // Clock
  input wire logic ref_clk,
  // Commands toward the bank
  output pmc_pkg::pmc_cmd_t cmd
);
  // ----
  // Bus host model
  // ----
  initial cmd = '0;
  // One command for one edge, fields scrambled while idle
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    cmd = {1'b1, w, c, d};
    @(posedge ref_clk);
    #1 cmd = {1'b0, ~w, ~c, ~d};
    @(posedge ref_clk);
    #1;
  endtask
  // General password first, then the address one if a is set
  task automatic unlock(input logic a);
    send(1'b1, 8'hc4, 16'hc93f);
    if (a) send(1'b1, 8'hc6, 16'hf1c0);
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  // ----
  // Stimulus and checks
  // ----
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic temp_lut_stored = 1'b0, gain_lut_stored = 1'b0, cfg_start = 1'b0, cfg_byte_valid = 1'b0, cfg_last = 1'b0;
  logic supply_restored = 1'b0, cfg_blank = 1'b0, ss_start = 1'b0, ss_end = 1'b0, recovery, mem_fault, ss_fault;
  logic [7:0] cfg_byte = 8'h00, bus_addr;
  logic [15:0] temp_lut_crc = 16'h0000, gain_lut_crc = 16'h0000, cfg_signature = 16'h0000, vout_mant = 16'h0400;
  pmc_pkg::pmc_cmd_t cmd;
  pmc_pkg::pmc_rsp_t rsp;
  pmc_pkg::pmc_meas_t iout_raw = '0, iout_cal;
  logic [17:0] rq[$], e; // Noted answers: check data, ack, data
  logic [10:0] iq[$]; // Noted currents
  logic [15:0] v[7]; // Values held by the bank
  logic [7:0] code[7] = '{8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdf, 8'hf0, 8'hf1};
  logic [15:0] msk[7] = '{16'hffff, 16'h00ff, 16'hffff, 16'h00ff, 16'h003f, 16'h00ff, 16'h00ff};
  logic [31:0] rs = 32'h0001_2071; // Seed
  int n_fail = 0, n_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  pmc_regs #(.QUARTER_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .rsp(rsp),
    .temp_lut_stored(temp_lut_stored), .gain_lut_stored(gain_lut_stored), .temp_lut_crc(temp_lut_crc),
    .gain_lut_crc(gain_lut_crc), .cfg_start(cfg_start), .cfg_byte_valid(cfg_byte_valid), .cfg_byte(cfg_byte),
    .cfg_last(cfg_last), .cfg_signature(cfg_signature), .supply_restored(supply_restored), .cfg_blank(cfg_blank),
    .bus_addr(bus_addr), .recovery(recovery), .mem_fault(mem_fault), .iout_raw(iout_raw), .iout_cal(iout_cal),
    .ss_start(ss_start), .ss_end(ss_end), .vout_mant(vout_mant), .ss_fault(ss_fault));
  pmc_host i_host (.ref_clk(ref_clk), .cmd(cmd));
  // Xorshift source
  function automatic logic [15:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction
  // Clamp to the mantissa range
  function automatic int sat(input int x);
    return x < 0 ? 0 : (x > 2047 ? 2047 : x);
  endfunction
  // Trim, then the two threshold stages
  function automatic logic [10:0] cal(input logic [10:0] m);
    int x, t, g;
    x = int'(m) + (v[5][7] ? -int'(v[5][6:0]) : int'(v[5][6:0]));
    x = sat(sat(x) * int'(v[6][7:0]) / 128);
    for (int k = 0; k < 2; k++) begin
      t = int'(v[2 * k][10:0]);
      g = int'(v[2 * k + 1][7:0]);
      if (t != 0 && x > t) x = sat(x + g * (x - t) / 64);
    end
    return x[10:0];
  endfunction
  // Checksum of four bytes, high bit first
  function automatic logic [15:0] crc16(input logic [31:0] w);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Command with its noted answer
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic a, input logic [15:0] x);
    rq.push_back({~w, a, x});
    i_host.send(w, c, d);
  endtask
  task automatic unlock(input logic a);
    repeat (1 + a) rq.push_back(18'h1_0000);
    i_host.unlock(a);
  endtask
  // Bounded wait for the live address
  task automatic wait_addr(input logic [7:0] x);
    for (int k = 0; k < 8 && bus_addr !== x; k++) @(posedge ref_clk);
    #1 chk({8'h00, bus_addr}, {8'h00, x}, "bus_addr");
    if (bus_addr !== x) summarize();
  endtask
  task automatic power(input logic blank, input logic [7:0] x);
    cfg_blank = blank;
    supply_restored = 1'b1;
    @(posedge ref_clk);
    #1 supply_restored = 1'b0;
    wait_addr(x);
  endtask
  // One configuration check run
  task automatic cfg_run(input logic ok, input logic [7:0] x, input logic f);
    logic [31:0] w;
    w = {rnd(), rnd()};
    cfg_signature = ok ? crc16(w) : ~crc16(w);
    cfg_start = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      @(posedge ref_clk);
      #1 cfg_start = 1'b0;
      cfg_byte_valid = 1'b1;
      cfg_byte = w[8 * i +: 8];
      cfg_last = (i == 0);
    end
    @(posedge ref_clk);
    #1 cfg_byte_valid = 1'b0;
    cfg_last = 1'b0;
    cfg_byte = ~cfg_byte;
    @(posedge ref_clk);
    #1 chk({15'h0000, recovery}, {15'h0000, ~ok}, "recovery");
    chk({15'h0000, mem_fault}, {15'h0000, f}, "mem_fault");
    @(posedge ref_clk);
    #1 chk({8'h00, bus_addr}, {8'h00, x}, "bus_addr");
    xfer(1'b0, 8'hee, 16'h0000, 1'b1, crc16(w));
  endtask
  // Soft-start run, fault expected lo cycles after start
  task automatic ss_run(input logic [7:0] step, input logic [7:0] tim, input logic rise, input int lo);
    int n;
    n = 0;
    xfer(1'b1, 8'hd4, {8'h00, step}, 1'b1, 16'h0000);
    xfer(1'b1, 8'hdf, {8'h00, tim}, 1'b1, 16'h0000);
    ss_start = 1'b1;
    @(posedge ref_clk);
    #1 ss_start = 1'b0;
    while (n < 90 && ss_fault !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      vout_mant = vout_mant + {15'h0000, rise};
    end
    chk({15'h0000, lo == 0 ? n == 90 : n >= lo && n <= lo + 5}, 16'h0001, "fault time");
    if (lo != 0 && n == 90) summarize();
    ss_end = 1'b1;
    @(posedge ref_clk);
    #1 ss_end = 1'b0;
  endtask
  // Answers and currents against the notes
  always @(posedge ref_clk) begin
    if (!rst && rsp.valid === 1'b1) begin
      e = rq.pop_front();
      chk({15'h0000, rsp.ack}, {15'h0000, e[16]}, "ack");
      if (e[17]) chk(rsp.data, e[15:0], "rdata");
    end
    if (!rst && iout_cal.valid === 1'b1) chk({5'h00, iout_cal.mant}, {5'h00, iq.pop_front()}, "iout");
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    xfer(1'b0, 8'hf1, 16'h0000, 1'b1, 16'h0080);
    for (int s = 0; s < 4; s++) begin
      {gain_lut_stored, temp_lut_stored} = s[1:0];
      xfer(1'b0, 8'hd8, 16'h0000, 1'b1, 16'(s));
    end
    xfer(1'b1, 8'hd9, 16'h1234, 1'b1, 16'h0000);
    xfer(1'b0, 8'hd9, 16'h0000, 1'b1, 16'h0000);
    unlock(1'b0);
    xfer(1'b0, 8'h00, 16'h0000, 1'b0, 16'h0000);
    xfer(1'b1, 8'hd8, 16'h0003, 1'b0, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      v[i] = rnd();
      if (i == 0 || i == 2) v[i][15:11] = 5'h1e;
      xfer(1'b1, code[i], v[i], 1'b1, 16'h0000);
      v[i] = v[i] & msk[i];
      xfer(1'b0, code[i], 16'h0000, 1'b1, v[i]);
    end
    temp_lut_crc = rnd();
    gain_lut_crc = rnd();
    xfer(1'b0, 8'he1, 16'h0000, 1'b1, temp_lut_crc);
    xfer(1'b0, 8'he2, 16'h0000, 1'b1, gain_lut_crc);
    xfer(1'b1, 8'he2, 16'h0000, 1'b0, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      iout_raw = {1'b1, 11'(rnd())};
      iq.push_back(cal(iout_raw.mant));
      @(posedge ref_clk);
      #1;
    end
    iout_raw = '0;
    xfer(1'b1, 8'he0, 16'h00e0, 1'b1, 16'h0000);
    xfer(1'b0, 8'he0, 16'h0000, 1'b1, 16'h0020);
    unlock(1'b1);
    xfer(1'b1, 8'he0, 16'h0060, 1'b1, 16'h0000);
    xfer(1'b0, 8'he0, 16'h0000, 1'b1, 16'h0060);
    repeat (4) @(posedge ref_clk);
    wait_addr(8'h10);
    power(1'b0, 8'h30);
    power(1'b1, 8'h10);
    ss_run(8'h05, 8'h03, 1'b0, 20);
    ss_run(8'h05, 8'h3f, 1'b0, 64);
    ss_run(8'h05, 8'h00, 1'b1, 0);
    ss_run(8'h00, 8'h03, 1'b0, 0);
    cfg_run(1'b1, 8'h10, 1'b0);
    cfg_run(1'b0, 8'hb0, 1'b1);
    cfg_run(1'b1, 8'h10, 1'b1);
    for (int k = 0; k < 10 && rq.size() + iq.size() != 0; k++) @(posedge ref_clk);
    chk(16'(rq.size() + iq.size()), 16'h0000, "pending");
    summarize();
  end
endmodule
